// ==== design/ois_pkg.sv ====
// constants for the display command port and its reset defaults
// assumes one bus address and the two control bytes below
package ois_pkg;
  // ----------------------------------------------------------------
  // framing on the serial link
  // ----------------------------------------------------------------
  localparam logic [7:0] SLAVE_ADDR      = 8'h78;
  localparam logic [7:0] CTRL_CMD        = 8'h00;
  localparam logic [7:0] CTRL_DATA       = 8'h40;
  localparam logic [3:0] BIT_LAST        = 4'h7;
  localparam logic [3:0] BIT_ACK         = 4'h8;
  localparam logic [1:0] IDX_ADDR        = 2'h0;
  localparam logic [1:0] IDX_CTRL        = 2'h1;
  localparam logic [1:0] IDX_PAYLOAD     = 2'h2;
  localparam logic [1:0] IDX_DONE        = 2'h3;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DISP_OFF    = 8'hae;
  localparam logic [7:0] CMD_DISP_ON     = 8'haf;
  localparam logic [7:0] CMD_FOLLOW_RAM  = 8'ha4;
  localparam logic [7:0] CMD_ALL_ON      = 8'ha5;
  localparam logic [7:0] CMD_NORMAL      = 8'ha6;
  localparam logic [7:0] CMD_INVERSE     = 8'ha7;
  localparam logic [7:0] CMD_SEG_NORMAL  = 8'ha0;
  localparam logic [7:0] CMD_SEG_REMAP   = 8'ha1;
  localparam logic [7:0] CMD_SCAN_NORMAL = 8'hc0;
  localparam logic [7:0] CMD_SCAN_REV    = 8'hc8;
  localparam logic [7:0] CMD_CONTRAST    = 8'h81;
  localparam logic [7:0] CMD_PUMP        = 8'h8d;
  localparam logic [7:0] CMD_MUX         = 8'ha8;
  localparam logic [7:0] CMD_OFFSET      = 8'hd3;
  localparam logic [7:0] CMD_OSC         = 8'hd5;
  localparam logic [7:0] CMD_PRECHARGE   = 8'hd9;
  localparam logic [7:0] CMD_ROW_PINS    = 8'hda;
  localparam logic [7:0] CMD_DESELECT    = 8'hdb;
  localparam int         PUMP_EN_BIT     = 2;
  // ----------------------------------------------------------------
  // reset defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONTRAST    = 8'h7f;
  localparam logic [5:0] RST_MUX         = 6'h3f;
  localparam logic [5:0] RST_START_LINE  = 6'h00;
  localparam logic [6:0] RST_COLUMN      = 7'h00;
endpackage

// ==== design/ois_sequencer.sv ====
// display command port: serial byte receiver on the host clock and
// command interpreter on clk; assumes the host frames every byte as
// start, address, control byte, payload, stop
//
// Function
// - panel reset low: display off, normal ram-following mode
// - reset: segment and row mapping unremapped, first outputs at 00h
// - reset clears the serial shift register and bit count
// - reset sets display start line to ram line 0
// - reset loads column address counter with zero
// - reset selects normal row scan direction
// - reset loads contrast with 7fh
`timescale 1ns/1ps
module ois_sequencer (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       panel_reset_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            display_on,
  output logic            entire_on,
  output logic            inverse,
  output logic            seg_remap,
  output logic            scan_reverse,
  output logic [7:0]      contrast,
  output logic [5:0]      start_line,
  output logic [5:0]      mux_ratio,
  output logic            pump_enable,
  output logic [6:0]      column,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic [6:0]      data_column
);
  typedef enum logic [4:0] {
    ARG_NONE     = 5'b00001,
    ARG_CONTRAST = 5'b00010,
    ARG_PUMP     = 5'b00100,
    ARG_MUX      = 5'b01000,
    ARG_SKIP     = 5'b10000
  } ois_arg_e;

  // ----------------------------------------------------------------
  // panel reset pin sync and link reset
  // ----------------------------------------------------------------
  logic [2:0] prst_sync;
  logic       prst_level;
  logic       link_clr;
  logic [2:0] next_prst_sync;
  logic       next_prst_level;
  logic       next_link_clr;
  logic       core_rst;

  always_comb begin
    next_prst_sync  = {prst_sync[1:0], panel_reset_n};
    next_prst_level = prst_level;
    if (prst_sync[1] == prst_sync[2]) begin
      next_prst_level = prst_sync[2];
    end
    next_link_clr = rst | ~prst_level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prst_sync  <= 3'h7;
      prst_level <= 1'b1;
      link_clr   <= 1'b1;
    end else begin
      prst_sync  <= next_prst_sync;
      prst_level <= next_prst_level;
      link_clr   <= next_link_clr;
    end
  end

  assign core_rst = rst | ~prst_level;

  // ----------------------------------------------------------------
  // link side, rising host clock: shift and frame
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt;
  logic [6:0] shreg;
  logic [1:0] byte_idx;
  logic       addr_ok;
  logic       ctrl_ok;
  logic       is_data;
  logic       ack;
  logic [8:0] word;
  logic       word_tog;
  logic       frame_start;
  logic [3:0] next_bit_cnt;
  logic [6:0] next_shreg;
  logic [1:0] next_byte_idx;
  logic       next_addr_ok;
  logic       next_ctrl_ok;
  logic       next_is_data;
  logic       next_ack;
  logic [8:0] next_word;
  logic       next_word_tog;
  logic [7:0] rx_byte;

  always_comb begin
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_byte_idx = byte_idx;
    next_addr_ok  = addr_ok;
    next_ctrl_ok  = ctrl_ok;
    next_is_data  = is_data;
    next_ack      = ack;
    next_word     = word;
    next_word_tog = word_tog;
    rx_byte       = {shreg, sda_in};
    if (frame_start) begin
      next_bit_cnt  = 4'h1;
      next_shreg    = {6'h00, sda_in};
      next_byte_idx = ois_pkg::IDX_ADDR;
      next_addr_ok  = 1'b0;
      next_ctrl_ok  = 1'b0;
      next_ack      = 1'b0;
    end else if (bit_cnt == ois_pkg::BIT_ACK) begin
      next_bit_cnt = 4'h0;
    end else if (bit_cnt == ois_pkg::BIT_LAST) begin
      next_bit_cnt = ois_pkg::BIT_ACK;
      next_ack     = 1'b0;
      if (byte_idx != ois_pkg::IDX_DONE) begin
        next_byte_idx = byte_idx + 2'h1;
      end
      if (byte_idx == ois_pkg::IDX_ADDR) begin
        next_addr_ok = (rx_byte == ois_pkg::SLAVE_ADDR);
        next_ack     = next_addr_ok;
      end else if (byte_idx == ois_pkg::IDX_CTRL) begin
        next_ctrl_ok = addr_ok & ((rx_byte == ois_pkg::CTRL_CMD) |
                                  (rx_byte == ois_pkg::CTRL_DATA));
        next_is_data = (rx_byte == ois_pkg::CTRL_DATA);
        next_ack     = next_ctrl_ok;
      end else if (byte_idx == ois_pkg::IDX_PAYLOAD && ctrl_ok) begin
        next_word     = {is_data, rx_byte};
        next_word_tog = ~word_tog;
        next_ack      = 1'b1;
      end
    end else begin
      next_bit_cnt = bit_cnt + 4'h1;
      next_shreg   = {shreg[5:0], sda_in};
    end
  end

  always_ff @(posedge scl or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt  <= 4'h0;
      shreg    <= 7'h00;
      byte_idx <= ois_pkg::IDX_DONE;
      addr_ok  <= 1'b0;
      ctrl_ok  <= 1'b0;
      is_data  <= 1'b0;
      ack      <= 1'b0;
      word     <= 9'h000;
      word_tog <= 1'b0;
    end else begin
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      byte_idx <= next_byte_idx;
      addr_ok  <= next_addr_ok;
      ctrl_ok  <= next_ctrl_ok;
      is_data  <= next_is_data;
      ack      <= next_ack;
      word     <= next_word;
      word_tog <= next_word_tog;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling data: start marker
  // ----------------------------------------------------------------
  logic start_tog;
  logic next_start_tog;

  // data fell while clock high; stop then start in one high phase counts
  always_comb begin
    next_start_tog = start_tog ^ scl;
  end

  always_ff @(negedge sda_in or posedge link_clr) begin
    if (link_clr) begin
      start_tog <= 1'b0;
    end else begin
      start_tog <= next_start_tog;
    end
  end

  // ----------------------------------------------------------------
  // link side, falling host clock: start detect and acknowledge
  // ----------------------------------------------------------------
  logic start_seen;
  logic next_start_seen;
  logic next_frame_start;
  logic next_sda_oe;

  always_comb begin
    // new start marker since the last clock fall
    next_start_seen  = start_tog;
    next_frame_start = start_tog ^ start_seen;
    next_sda_oe      = (bit_cnt == ois_pkg::BIT_ACK) & ack & ~next_frame_start;
  end

  always_ff @(negedge scl or posedge link_clr) begin
    if (link_clr) begin
      start_seen  <= 1'b0;
      frame_start <= 1'b0;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
    end else begin
      start_seen  <= next_start_seen;
      frame_start <= next_frame_start;
      sda_oe      <= next_sda_oe;
      sda_out     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // core: byte arrival and interpreter
  // ----------------------------------------------------------------
  logic [2:0] tog_sync;
  ois_arg_e   arg_st;
  logic [2:0] next_tog_sync;
  ois_arg_e   next_arg_st;
  logic       next_display_on;
  logic       next_entire_on;
  logic       next_inverse;
  logic       next_seg_remap;
  logic       next_scan_reverse;
  logic [7:0] next_contrast;
  logic [5:0] next_start_line;
  logic [5:0] next_mux_ratio;
  logic       next_pump_enable;
  logic [6:0] next_column;
  logic       next_data_valid;
  logic [7:0] next_data_byte;
  logic [6:0] next_data_column;
  logic       got;
  logic [7:0] b;

  always_comb begin
    next_tog_sync     = {tog_sync[1:0], word_tog};
    next_arg_st       = arg_st;
    next_display_on   = display_on;
    next_entire_on    = entire_on;
    next_inverse      = inverse;
    next_seg_remap    = seg_remap;
    next_scan_reverse = scan_reverse;
    next_contrast     = contrast;
    next_start_line   = start_line;
    next_mux_ratio    = mux_ratio;
    next_pump_enable  = pump_enable;
    next_column       = column;
    next_data_valid   = 1'b0;
    next_data_byte    = data_byte;
    next_data_column  = data_column;
    got               = tog_sync[1] ^ tog_sync[2];
    b                 = word[7:0];
    if (got && word[8]) begin
      next_data_valid  = 1'b1;
      next_data_byte   = b;
      next_data_column = column;
      next_column      = column + 7'h01;
    end else if (got) begin
      next_arg_st = ARG_NONE;
      case (arg_st)
        ARG_CONTRAST: begin
          next_contrast = b;
        end
        ARG_PUMP: begin
          next_pump_enable = b[ois_pkg::PUMP_EN_BIT];
        end
        ARG_MUX: begin
          next_mux_ratio = b[5:0];
        end
        ARG_SKIP: begin
        end
        default: begin
          if (b == ois_pkg::CMD_DISP_OFF) begin
            next_display_on = 1'b0;
          end else if (b == ois_pkg::CMD_DISP_ON) begin
            next_display_on = 1'b1;
          end else if (b == ois_pkg::CMD_FOLLOW_RAM) begin
            next_entire_on = 1'b0;
          end else if (b == ois_pkg::CMD_ALL_ON) begin
            next_entire_on = 1'b1;
          end else if (b == ois_pkg::CMD_NORMAL) begin
            next_inverse = 1'b0;
          end else if (b == ois_pkg::CMD_INVERSE) begin
            next_inverse = 1'b1;
          end else if (b == ois_pkg::CMD_SEG_NORMAL) begin
            next_seg_remap = 1'b0;
          end else if (b == ois_pkg::CMD_SEG_REMAP) begin
            next_seg_remap = 1'b1;
          end else if (b == ois_pkg::CMD_SCAN_NORMAL) begin
            next_scan_reverse = 1'b0;
          end else if (b == ois_pkg::CMD_SCAN_REV) begin
            next_scan_reverse = 1'b1;
          end else if (b == ois_pkg::CMD_CONTRAST) begin
            next_arg_st = ARG_CONTRAST;
          end else if (b == ois_pkg::CMD_PUMP) begin
            next_arg_st = ARG_PUMP;
          end else if (b == ois_pkg::CMD_MUX) begin
            next_arg_st = ARG_MUX;
          end else if (b == ois_pkg::CMD_OFFSET || b == ois_pkg::CMD_OSC ||
                       b == ois_pkg::CMD_PRECHARGE || b == ois_pkg::CMD_ROW_PINS ||
                       b == ois_pkg::CMD_DESELECT) begin
            next_arg_st = ARG_SKIP;
          end else if (b[7:6] == 2'h1) begin
            next_start_line = b[5:0];
          end else if (b[7:4] == 4'h0) begin
            next_column = {column[6:4], b[3:0]};
          end else if (b[7:4] == 4'h1) begin
            next_column = {b[2:0], column[3:0]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    tog_sync <= next_tog_sync;
    if (core_rst) begin
      arg_st       <= ARG_NONE;
      display_on   <= 1'b0;
      entire_on    <= 1'b0;
      inverse      <= 1'b0;
      seg_remap    <= 1'b0;
      scan_reverse <= 1'b0;
      contrast     <= ois_pkg::RST_CONTRAST;
      start_line   <= ois_pkg::RST_START_LINE;
      mux_ratio    <= ois_pkg::RST_MUX;
      pump_enable  <= 1'b0;
      column       <= ois_pkg::RST_COLUMN;
      data_valid   <= 1'b0;
      data_byte    <= 8'h00;
      data_column  <= 7'h00;
    end else begin
      arg_st       <= next_arg_st;
      display_on   <= next_display_on;
      entire_on    <= next_entire_on;
      inverse      <= next_inverse;
      seg_remap    <= next_seg_remap;
      scan_reverse <= next_scan_reverse;
      contrast     <= next_contrast;
      start_line   <= next_start_line;
      mux_ratio    <= next_mux_ratio;
      pump_enable  <= next_pump_enable;
      column       <= next_column;
      data_valid   <= next_data_valid;
      data_byte    <= next_data_byte;
      data_column  <= next_data_column;
    end
  end
endmodule

// ==== tb/ois_asserts.sv ====
// checker for the display command port, bound to ois_sequencer
// assumes a 40 MHz clk and a 160 ns serial clock from the host
`timescale 1ns/1ps
module ois_asserts (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       panel_reset_n,
  input wire logic       scl,
  input wire logic       sda_oe,
  input wire logic       display_on,
  input wire logic       entire_on,
  input wire logic       inverse,
  input wire logic       seg_remap,
  input wire logic       scan_reverse,
  input wire logic [7:0] contrast,
  input wire logic [5:0] start_line,
  input wire logic [6:0] column,
  input wire logic       data_valid,
  input wire logic [6:0] data_column
);
  default clocking cb @(posedge clk); endclocking
  // ------------------------------
  // reset defaults
  // ------------------------------
  AST_RST_DISPLAY: assert property (rst |=> !display_on && !entire_on && !inverse)
    else $error("display state kept in reset");
  AST_RST_MAP: assert property (rst |=> !seg_remap)
    else $error("segment remap kept in reset");
  AST_RST_LINK: assert property (rst ##1 rst |-> !sda_oe)
    else $error("receiver active in reset");
  AST_RST_START: assert property (rst |=> start_line == 6'h00)
    else $error("start line not cleared");
  AST_RST_COLUMN: assert property (rst |=> column == 7'h00)
    else $error("column not cleared");
  AST_RST_SCAN: assert property (rst |=> !scan_reverse)
    else $error("scan direction kept in reset");
  AST_RST_CONTRAST: assert property (rst |=> contrast == 8'h7f)
    else $error("contrast not at default");
  sequence s_panel_held;
    !panel_reset_n [*7];
  endsequence
  AST_PANEL_HELD: assert property (disable iff (rst) s_panel_held |->
    !display_on && !inverse && !entire_on && column == 7'h00 && contrast == 8'h7f)
    else $error("panel reset did not restore defaults");
  // ------------------------------
  // data strobe and acknowledge
  // ------------------------------
  sequence s_ack_slot;
    sda_oe [*5] ##[1:3] !sda_oe;
  endsequence
  AST_STROBE: assert property (disable iff (rst) data_valid |=> !data_valid)
    else $error("data strobe too long");
  AST_COLUMN_STEP: assert property (disable iff (rst) data_valid |->
    column == data_column + 7'h01)
    else $error("column not stepped with data");
  AST_ACK_EDGE: assert property (disable iff (rst) $changed(sda_oe) |-> !scl)
    else $error("ack changed while clock high");
  AST_ACK_SLOT: assert property (disable iff (rst) $rose(sda_oe) |-> s_ack_slot)
    else $error("ack not one clock wide");
endmodule

bind ois_sequencer ois_asserts chk (.clk, .rst, .panel_reset_n, .scl, .sda_oe, .display_on,
  .entire_on, .inverse, .seg_remap, .scan_reverse, .contrast, .start_line, .column,
  .data_valid, .data_column);

// ==== tb/ois_host.sv ====
// host master model: drives the serial clock and data
// assumes the bench makes the wire from a pull-up and the device's pull-down
`timescale 1ns/1ps
module ois_host (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // idle: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic put_bits(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      sda_drv = b[i];
      #40 scl = 1'b1;
      #80 scl = 1'b0;
      #40;
    end
    if (n == 8) begin
      sda_drv = 1'b1;
      #40 scl = 1'b1;
      ack = !sda_line;
      #80 scl = 1'b0;
      #40;
    end
  endtask
  task automatic frame(input logic [7:0] adr, ctl, pay, output logic [2:0] acks);
    sda_drv = 1'b0;
    #80 scl = 1'b0;
    #40;
    put_bits(adr, 8, acks[2]);
    put_bits(ctl, 8, acks[1]);
    put_bits(pay, 8, acks[0]);
    sda_drv = 1'b0;
    #40 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #160;
  endtask
  // frame cut short inside the address byte
  task automatic abort();
    logic ack;
    sda_drv = 1'b0;
    #80 scl = 1'b0;
    #40;
    put_bits(8'h78, 4, ack);
  endtask
  task automatic idle();
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #160;
  endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the display command port
// assumes the host model drives the link and the checker is bound
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        panel_reset_n = 1'b1;
  logic        scl, sda_drv, sda_in, sda_out, sda_oe;
  logic        display_on, entire_on, inverse, seg_remap, scan_reverse;
  logic        pump_enable, data_valid;
  logic [7:0]  contrast, data_byte;
  logic [5:0]  start_line, mux_ratio;
  logic [6:0]  column, data_column, col;
  logic [15:0] exp_q[$];
  int          bad_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  integer      seed = 32'h713c;
  logic [7:0]  init_tab [18] = '{8'hae, 8'ha1, 8'ha6, 8'ha8, 8'h1f, 8'hc8, 8'hd3, 8'h00,
    8'hd5, 8'h80, 8'hd9, 8'h1f, 8'hda, 8'h00, 8'hdb, 8'h40, 8'h8d, 8'h10};
  // command, then {display_on, entire_on, inverse, seg_remap, scan_reverse}
  logic [12:0] mode_tab [10] = '{{8'ha5, 5'h1b}, {8'ha7, 5'h1f}, {8'ha4, 5'h17},
    {8'ha6, 5'h13}, {8'ha0, 5'h11}, {8'hc0, 5'h10}, {8'hae, 5'h00}, {8'ha1, 5'h02},
    {8'hc8, 5'h03}, {8'haf, 5'h13}};

  // open-drain wire with pull-up
  assign sda_in = sda_drv & !(sda_oe & !sda_out);
  always #12.5 clk = ~clk;

  ois_host host (.scl, .sda_drv, .sda_line(sda_in));
  ois_sequencer dut (.clk, .rst, .panel_reset_n, .scl, .sda_in, .sda_out, .sda_oe,
    .display_on, .entire_on, .inverse, .seg_remap, .scan_reverse, .contrast, .start_line,
    .mux_ratio, .pump_enable, .column, .data_valid, .data_byte, .data_column);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // one frame; expected acks and data noted first
  task automatic send(input logic [7:0] adr, ctl, pay);
    logic [2:0] acks;
    logic       ok_a, ok_c;
    ok_a = (adr === 8'h78);
    ok_c = ok_a && (ctl === 8'h00 || ctl === 8'h40);
    if (ok_c && ctl === 8'h40) begin
      exp_q.push_back({pay, 1'b0, col});
      col = col + 7'h01;
    end
    host.frame(adr, ctl, pay, acks);
    check(16'(acks), 16'({ok_a, ok_c, ok_c}));
    repeat (8) @(posedge clk);
  endtask

  task automatic cmd(input logic [7:0] c);
    send(8'h78, 8'h00, c);
  endtask

  task automatic check_defaults();
    check(16'({display_on, entire_on, inverse}), 16'h0);
    check(16'(seg_remap), 16'h0);
    check(16'(start_line), 16'h0);
    check(16'(column), 16'h0);
    check(16'(scan_reverse), 16'h0);
    check(16'(contrast), 16'h7f);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (data_valid === 1'b1) begin
      check({data_byte, 1'b0, data_column},
        exp_q.size() > 0 ? exp_q.pop_front() : 16'h0080);
    end
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    col = 7'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check_defaults();
    // power-up: off, setup, clear; panel settle time is the host's
    foreach (init_tab[i]) cmd(init_tab[i]);
    repeat (4) send(8'h78, 8'h40, 8'h00);
    cmd(8'h81);
    cmd(8'h8f);
    cmd(8'h45);
    cmd(8'haf);
    check(16'({display_on, seg_remap, scan_reverse, pump_enable}), 16'he);
    check({contrast, 2'b00, start_line}, 16'h8f05);
    check(16'(mux_ratio), 16'h1f);
    foreach (mode_tab[i]) begin
      cmd(mode_tab[i][12:5]);
      check(16'({display_on, entire_on, inverse, seg_remap, scan_reverse}),
        16'(mode_tab[i][4:0]));
    end
    // column pointer commands, low nibble then high bits
    cmd(8'h05);
    cmd(8'h12);
    col = 7'h25;
    check(16'(column), 16'h25);
    // refused frames, then random data
    send(8'h7a, 8'h40, 8'h55);
    send(8'h78, 8'h20, 8'h55);
    repeat (8) send(8'h78, 8'h40, 8'($random(seed)));
    // power-down: display off before the supplies drop
    cmd(8'hae);
    check(16'(display_on), 16'h0);
    panel_reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    check_defaults();
    panel_reset_n <= 1'b1;
    col = 7'h00;
    // link clear lifts one cycle after the synced pin
    repeat (8) @(posedge clk);
    send(8'h78, 8'h40, 8'ha5);
    // partial byte, then reset clears it
    host.abort();
    @(posedge clk);
    rst <= 1'b1;
    host.idle();
    @(posedge clk);
    rst <= 1'b0;
    col = 7'h00;
    repeat (4) @(posedge clk);
    send(8'h78, 8'h40, 8'h3c);
    check(16'(exp_q.size()), 16'h0);
    stop_test();
  end
endmodule
